/* File: common/charge_pkg.sv */
// Shared constants, register map and carrier types of the charge limit supervisor.
// Assumes a 100 MHz system clock; currents 0.1 A, voltages 0.1 V, power 10 mW per LSB.
package charge_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned CLK_KHZ = 100000;
   localparam int unsigned OVER_V_MS = 400;
   localparam int unsigned LOW_V_MS = 3000;
   localparam int unsigned LOW_P_MS = 3000;
   localparam int unsigned OVER_V_CYC = OVER_V_MS * CLK_KHZ;
   localparam int unsigned LOW_V_CYC = LOW_V_MS * CLK_KHZ;
   localparam int unsigned LOW_P_CYC = LOW_P_MS * CLK_KHZ;

   ////////////////////////////////////////////////////////////////////////////////
   // Station limits (internal; only STN_MAX_I reaches the vehicle, as the advertised maximum current)
   localparam logic [15:0] STN_MAX_I = 16'h1388;
   localparam logic [15:0] STN_MIN_I = 16'h000A;
   localparam logic [15:0] STN_MAX_V = 16'h3A98;
   localparam logic [15:0] STN_MIN_V = 16'h07D0;
   localparam logic [31:0] STN_MIN_P = 32'h0000C350;
   localparam logic [31:0] STN_MAX_P_RST = 32'h047868C0;
   localparam logic [15:0] INRUSH_I = 16'h0014;
   localparam logic [15:0] LOAD_DUMP_ADD = 16'h01F4;
   localparam logic [19:0] LOAD_DUMP_MUL = 20'h0000B;
   localparam logic [19:0] LOAD_DUMP_DIV = 20'h0000A;

   ////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TGT_I = 8'h04;
   localparam logic [7:0] REG_TGT_V = 8'h08;
   localparam logic [7:0] REG_REQ_P = 8'h0C;
   localparam logic [7:0] REG_VMAX_I = 8'h10;
   localparam logic [7:0] REG_VMAX_V = 8'h14;
   localparam logic [7:0] REG_VMAX_P = 8'h18;
   localparam logic [7:0] REG_SMAX_P = 8'h1C;
   localparam logic [7:0] REG_STATUS = 8'h20;
   localparam logic [7:0] REG_CMD_I = 8'h24;
   localparam logic [7:0] REG_CMD_V = 8'h28;
   localparam logic [7:0] REG_CMD_P = 8'h2C;
   localparam logic [7:0] REG_ADV_I = 8'h30;
   localparam logic [7:0] REG_OVS = 8'h34;

   // Control bit positions
   localparam int unsigned CTRL_EN = 0;
   localparam int unsigned CTRL_ERR_CLR = 1;
   localparam int unsigned CTRL_MSG_SENT = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } wbReq_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wbRsp_t;

   typedef struct packed {
      logic [15:0] tgtI;
      logic [15:0] tgtV;
      logic [31:0] reqP;
      logic [15:0] maxI;
      logic [15:0] maxV;
      logic [31:0] maxP;
   } vehReq_t;

endpackage

/* File: verilog/duration_timer.sv */
// Counts cycles while a condition holds and flags when it held longer than CYCLES.
// Assumes cond comes from logic on sys_clk.
module duration_timer #(
   parameter int unsigned CYCLES = 1
)(
   // System
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Condition and result
   input wire logic cond,
   output logic expired
);
   logic [31:0] count_q;
   logic [31:0] count_d;

   // Saturates one past the limit so a long condition cannot wrap
   assign count_d = !cond ? 32'h00000000 :
                    (count_q > CYCLES) ? count_q : count_q + 32'h00000001;
   assign expired = count_q > CYCLES;

   // Counter
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         count_q <= 32'h00000000;
      else
         count_q <= count_d;
   end

   property p_restart;
      @(posedge sys_clk) disable iff (sys_rst)
      !cond |=> (count_q == 32'h00000000) && !expired;
   endproperty
   a_restart: assert property (p_restart) else $error("timer did not restart");

endmodule

/* File: verilog/overshoot_limit.sv */
// Load dump ceiling: the larger of 110 percent of a voltage and that voltage plus 50 V.
// Purely combinational; the caller registers the result.
module overshoot_limit (
   // Vehicle maximum voltage
   input wire logic [15:0] vehMax,
   // Ceiling, one bit wider to hold 110 percent
   output logic [16:0] ceiling
);
   logic [19:0] pct;
   logic [16:0] plus;

   // Both candidates, then the larger
   assign pct = (20'(vehMax) * charge_pkg::LOAD_DUMP_MUL) / charge_pkg::LOAD_DUMP_DIV;
   assign plus = 17'(vehMax) + 17'(charge_pkg::LOAD_DUMP_ADD);
   assign ceiling = (pct[16:0] > plus) ? pct[16:0] : plus;

endmodule

/* File: verilog/charge_limit_supervisor.sv */
// Charge limit supervisor: clamps vehicle requests, drives power stage set points,
// runs the voltage and power duration guards. Wishbone classic register slave.
// Assumes measurements and contactorClosing come from logic on sys_clk.

module charge_limit_supervisor #(
   parameter int unsigned OverVoltCycles = charge_pkg::OVER_V_CYC,
   parameter int unsigned LowVoltCycles = charge_pkg::LOW_V_CYC,
   parameter int unsigned LowPowerCycles = charge_pkg::LOW_P_CYC
)(
   // System
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Register bus
   input wire charge_pkg::wbReq_t wbReq,
   output charge_pkg::wbRsp_t wbRsp,
   // Measurements
   input wire logic [15:0] measuredVoltage,
   input wire logic [15:0] measuredCurrent,
   input wire logic contactorClosing,
   // Power stage set points
   output logic [15:0] currentCommand,
   output logic [15:0] voltageCommand,
   output logic [31:0] powerCap,
   output logic [16:0] overshootCeiling,
   output logic zeroCurrentMode,
   output logic errorStop,
   // Toward the message layer
   output logic [15:0] advertisedMaxCurrent,
   output logic reportPending
);
   import charge_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // State
   wbRsp_t rsp_q;
   vehReq_t veh_q;
   logic enable_q;
   logic [31:0] stnMaxP_q;
   logic [15:0] curCmd_q;
   logic [15:0] volCmd_q;
   logic [31:0] pCap_q;
   logic [16:0] ovs_q;
   logic zcm_q;
   logic errStop_q;
   logic ovErr_q;
   logic uvErr_q;
   logic [15:0] advI_q;
   logic report_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode
   logic access;
   logic wrStb;
   logic [31:0] wrData;
   logic [31:0] rdData;
   logic hitCtrl, hitTgtI, hitTgtV, hitReqP, hitMaxI, hitMaxV, hitMaxP, hitSmaxP;
   logic msgSent;
   logic errClr;
   logic ovExp, uvExp, lowPExp;

   // One-cycle answer; the ack flop itself blocks a second strobe on the same request
   assign access = wbReq.cyc && wbReq.stb && !rsp_q.ack;
   assign wrStb = access && wbReq.we;
   assign hitCtrl = wrStb && (wbReq.adr == REG_CTRL);
   assign hitTgtI = wrStb && (wbReq.adr == REG_TGT_I);
   assign hitTgtV = wrStb && (wbReq.adr == REG_TGT_V);
   assign hitReqP = wrStb && (wbReq.adr == REG_REQ_P);
   assign hitMaxI = wrStb && (wbReq.adr == REG_VMAX_I);
   assign hitMaxV = wrStb && (wbReq.adr == REG_VMAX_V);
   assign hitMaxP = wrStb && (wbReq.adr == REG_VMAX_P);
   assign hitSmaxP = wrStb && (wbReq.adr == REG_SMAX_P);
   assign msgSent = hitCtrl && wbReq.sel[0] && wbReq.dat[CTRL_MSG_SENT];
   assign errClr = hitCtrl && wbReq.sel[0] && wbReq.dat[CTRL_ERR_CLR];

   // Byte lanes not selected keep the stored value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
            res[8*b +: 8] = nw[8*b +: 8];
      end
      return res;
   endfunction

   assign wrData = merge(rdData, wbReq.dat, wbReq.sel);

   // Read selection; unmapped offsets read zero and writes there are dropped
   assign rdData =
      (wbReq.adr == REG_CTRL) ? {31'h00000000, enable_q} :
      (wbReq.adr == REG_TGT_I) ? {16'h0000, veh_q.tgtI} :
      (wbReq.adr == REG_TGT_V) ? {16'h0000, veh_q.tgtV} :
      (wbReq.adr == REG_REQ_P) ? veh_q.reqP :
      (wbReq.adr == REG_VMAX_I) ? {16'h0000, veh_q.maxI} :
      (wbReq.adr == REG_VMAX_V) ? {16'h0000, veh_q.maxV} :
      (wbReq.adr == REG_VMAX_P) ? veh_q.maxP :
      (wbReq.adr == REG_SMAX_P) ? stnMaxP_q :
      (wbReq.adr == REG_STATUS) ?
         {26'h0000000, lowPExp, report_q, uvErr_q, ovErr_q, errStop_q, zcm_q} :
      (wbReq.adr == REG_CMD_I) ? {16'h0000, curCmd_q} :
      (wbReq.adr == REG_CMD_V) ? {16'h0000, volCmd_q} :
      (wbReq.adr == REG_CMD_P) ? pCap_q :
      (wbReq.adr == REG_ADV_I) ? {16'h0000, advI_q} :
      (wbReq.adr == REG_OVS) ? {15'h0000, ovs_q} : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////////
   // Duration guards
   logic [31:0] measP;
   logic [31:0] tgtP;
   logic [15:0] minV;
   logic ovCond, uvCond, lowPCond;

   assign measP = 32'(measuredVoltage) * 32'(measuredCurrent);
   assign tgtP = 32'(measuredVoltage) * 32'(veh_q.tgtI);
   assign minV = (measuredVoltage < veh_q.tgtV) ? measuredVoltage : veh_q.tgtV;
   assign ovCond = enable_q && (measuredVoltage >= STN_MAX_V);
   assign uvCond = enable_q && (minV < STN_MIN_V);
   assign lowPCond = enable_q && (tgtP < STN_MIN_P);

   duration_timer #(.CYCLES(OverVoltCycles)) ovTimer (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .cond(ovCond),
      .expired(ovExp)
   );

   duration_timer #(.CYCLES(LowVoltCycles)) uvTimer (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .cond(uvCond),
      .expired(uvExp)
   );

   duration_timer #(.CYCLES(LowPowerCycles)) lowPTimer (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .cond(lowPCond),
      .expired(lowPExp)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Limits and set points
   logic cannotDeliver;
   logic zcm_d;
   logic [15:0] maxI;
   logic [15:0] clampI;
   logic [31:0] capP;
   logic [31:0] reqMinP;
   logic powerOver;
   logic [31:0] quotI;
   logic [15:0] powI;
   logic [15:0] limI;
   logic [15:0] curCmd_d;
   logic [15:0] volCmd_d;
   logic [15:0] advI_d;
   logic [16:0] ovs_d;

   // Zero station power or a standing error means no current can flow
   assign cannotDeliver = (stnMaxP_q == 32'h00000000) || errStop_q;
   // Minimum power is a package constant with no register: never sent or written
   assign zcm_d = !enable_q || errStop_q || cannotDeliver
                  || (veh_q.tgtI < STN_MIN_I)
                  || (veh_q.reqP < STN_MIN_P)
                  || lowPExp;

   assign maxI = (veh_q.maxI < STN_MAX_I) ? veh_q.maxI : STN_MAX_I;
   assign clampI = (veh_q.tgtI > maxI) ? maxI : veh_q.tgtI;
   // Requested power from the demand message, maximum from the separate limit
   assign capP = (veh_q.maxP < stnMaxP_q) ? veh_q.maxP : stnMaxP_q;
   assign reqMinP = (tgtP < veh_q.reqP) ? tgtP : veh_q.reqP;
   assign powerOver = (reqMinP > capP) || (measP > stnMaxP_q);
   // Division per cycle is slow, and the set point follows measured voltage and current every cycle
   assign quotI = (measuredVoltage == 16'h0000) ? 32'hFFFFFFFF : capP / 32'(measuredVoltage);
   assign powI = (quotI > 32'h0000FFFF) ? 16'hFFFF : quotI[15:0];
   assign limI = (powerOver && (powI < clampI)) ? powI : clampI;
   assign curCmd_d = zcm_d ? 16'h0000 :
                     (contactorClosing && (limI > INRUSH_I)) ? INRUSH_I : limI;
   // Battery maximum is not enforced here; station maximum bounds the request
   assign volCmd_d = (veh_q.tgtV > STN_MAX_V) ? STN_MAX_V : veh_q.tgtV;
   assign advI_d = cannotDeliver ? 16'h0000 : STN_MAX_I;

   overshoot_limit ovsCalc (
      .vehMax(veh_q.maxV),
      .ceiling(ovs_d)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Bus response and software registers
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rsp_q <= '0;
         enable_q <= 1'b0;
         veh_q <= '0;
         stnMaxP_q <= STN_MAX_P_RST;
      end
      else
      begin
         rsp_q.ack <= access;
         rsp_q.dat <= access && !wbReq.we ? rdData : 32'h00000000;
         if (hitCtrl)
            enable_q <= wrData[CTRL_EN];
         if (hitTgtI)
            veh_q.tgtI <= wrData[15:0];
         if (hitTgtV)
            veh_q.tgtV <= wrData[15:0];
         if (hitReqP)
            veh_q.reqP <= wrData;
         if (hitMaxI)
            veh_q.maxI <= wrData[15:0];
         if (hitMaxV)
            veh_q.maxV <= wrData[15:0];
         if (hitMaxP)
            veh_q.maxP <= wrData;
         if (hitSmaxP)
            stnMaxP_q <= wrData;
      end
   end

   // Set points, registered so every output comes from a flop
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         curCmd_q <= 16'h0000;
         volCmd_q <= 16'h0000;
         pCap_q <= 32'h00000000;
         ovs_q <= 17'h00000;
         zcm_q <= 1'b1;
         advI_q <= 16'h0000;
      end
      else
      begin
         curCmd_q <= curCmd_d;
         volCmd_q <= volCmd_d;
         pCap_q <= capP;
         ovs_q <= ovs_d;
         zcm_q <= zcm_d;
         advI_q <= advI_d;
      end
   end

   // Sticky flags: a new event wins over a clear in the same cycle
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ovErr_q <= 1'b0;
         uvErr_q <= 1'b0;
         errStop_q <= 1'b0;
         report_q <= 1'b0;
      end
      else
      begin
         ovErr_q <= ovExp || (ovErr_q && !errClr);
         uvErr_q <= uvExp || (uvErr_q && !errClr);
         errStop_q <= ovExp || uvExp || (errStop_q && !errClr);
         report_q <= (hitSmaxP && (wrData != stnMaxP_q)) || (advI_d != advI_q)
                     || (report_q && !msgSent);
      end
   end

   assign wbRsp = rsp_q;
   assign currentCommand = curCmd_q;
   assign voltageCommand = volCmd_q;
   assign powerCap = pCap_q;
   assign overshootCeiling = ovs_q;
   assign zeroCurrentMode = zcm_q;
   assign errorStop = errStop_q;
   assign advertisedMaxCurrent = advI_q;
   assign reportPending = report_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_lowCurZero;
      @(posedge sys_clk) disable iff (sys_rst)
      (veh_q.tgtI < STN_MIN_I) |=> zcm_q && (curCmd_q == 16'h0000);
   endproperty
   a_lowCurZero: assert property (p_lowCurZero) else $error("low target not zeroed");

   property p_curClamp;
      @(posedge sys_clk) disable iff (sys_rst)
      ##1 curCmd_q <= $past(maxI);
   endproperty
   a_curClamp: assert property (p_curClamp) else $error("current above maximum");

   property p_ovStop;
      @(posedge sys_clk) disable iff (sys_rst)
      ovExp |=> errStop_q && ovErr_q;
   endproperty
   a_ovStop: assert property (p_ovStop) else $error("overvoltage not stopped");

   property p_uvStop;
      @(posedge sys_clk) disable iff (sys_rst)
      uvExp |=> errStop_q && uvErr_q;
   endproperty
   a_uvStop: assert property (p_uvStop) else $error("undervoltage not stopped");

   property p_voltHold;
      @(posedge sys_clk) disable iff (sys_rst)
      (veh_q.tgtV > STN_MAX_V) && $stable(veh_q.tgtV) |=> volCmd_q == STN_MAX_V;
   endproperty
   a_voltHold: assert property (p_voltHold) else $error("voltage not held at max");

   property p_lowPower;
      @(posedge sys_clk) disable iff (sys_rst)
      (veh_q.reqP < STN_MIN_P) || lowPExp |=> zcm_q;
   endproperty
   a_lowPower: assert property (p_lowPower) else $error("low power not zeroed");

   property p_report;
      @(posedge sys_clk) disable iff (sys_rst)
      hitSmaxP && (wrData != stnMaxP_q) |=> report_q;
   endproperty
   a_report: assert property (p_report) else $error("limit change not flagged");

   property p_inrush;
      @(posedge sys_clk) disable iff (sys_rst)
      contactorClosing |=> curCmd_q <= INRUSH_I;
   endproperty
   a_inrush: assert property (p_inrush) else $error("inrush above limit");

   property p_zeroHold;
      @(posedge sys_clk) disable iff (sys_rst)
      zcm_q |-> curCmd_q == 16'h0000;
   endproperty
   a_zeroHold: assert property (p_zeroHold) else $error("current in zero mode");

   property p_advZero;
      @(posedge sys_clk) disable iff (sys_rst)
      cannotDeliver |=> advI_q == 16'h0000 ##1 report_q || advI_q == 16'h0000;
   endproperty
   a_advZero: assert property (p_advZero) else $error("max current not zeroed");

endmodule

/* File: verification/vehicle_model.sv */
// Vehicle charge controller model: its demand messages reach the supervisor over the
// register bus. Assumes a Wishbone classic slave on sys_clk that always answers.
module vehicle_model
   import charge_pkg::*;
(
   // System
   input wire logic sys_clk,
   // Register bus
   input wire charge_pkg::wbRsp_t wbRsp,
   output charge_pkg::wbReq_t wbReq,
   // Session
   output logic stopReq
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////////
   // Idle bus; a shortfall of delivered current is never a reason to stop
   initial
   begin
      wbReq = '0;
      stopReq = 1'h0;
   end

   // One classic cycle; request held until ack is sampled on a rising edge
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge sys_clk);
      wbReq <= '{cyc: 1'h1, stb: 1'h1, we: we, sel: 4'hF, adr: adr, dat: wd};
      @(posedge sys_clk);
      while (wbRsp.ack !== 1'h1)
      begin
         @(posedge sys_clk);
      end
      rd = wbRsp.dat;
      wbReq <= '0;
   endtask

   // Demand message; requested power and overall maximum power are separate values
   task automatic send(input vehReq_t m);
      logic [31:0] rd;
      xfer(1'h1, REG_TGT_I, {16'h0000, m.tgtI}, rd);
      xfer(1'h1, REG_TGT_V, {16'h0000, m.tgtV}, rd);
      xfer(1'h1, REG_REQ_P, m.reqP, rd);
      xfer(1'h1, REG_VMAX_I, {16'h0000, m.maxI}, rd);
      xfer(1'h1, REG_VMAX_V, {16'h0000, m.maxV}, rd);
      xfer(1'h1, REG_VMAX_P, m.maxP, rd);
   endtask
endmodule

/* File: verification/tb.sv */
// Self-checking bench of the charge limit supervisor with short guard timers.
// Assumes the vehicle model drives the register bus.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import charge_pkg::*;

   typedef struct packed {
      vehReq_t m;
      logic [15:0] volt;
      logic [15:0] expI;
      logic [15:0] expV;
      logic expZ;
      logic [31:0] expCap;
      logic [16:0] expOvs;
   } row_t;

   logic sys_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic [15:0] measV = 16'h0FA0;
   logic [15:0] measI = 16'h0000;
   logic closing = 1'h0;
   wbReq_t wbReq;
   wbRsp_t wbRsp;
   logic [15:0] currentCommand, voltageCommand, advertisedMaxCurrent;
   logic [31:0] powerCap, rd;
   logic [16:0] overshootCeiling;
   logic zeroCurrentMode, errorStop, reportPending;
   int nErrors = 0;
   int testsRun = 0;
   int cycles = 0;
   row_t rows [6];
   vehReq_t m;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and instances; guards shortened to 20 cycles to keep the run short
   initial
   begin
      forever #5 sys_clk = ~sys_clk;
   end

   charge_limit_supervisor #(.OverVoltCycles(20), .LowVoltCycles(20), .LowPowerCycles(20))
   i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .wbReq(wbReq), .wbRsp(wbRsp),
      .measuredVoltage(measV), .measuredCurrent(measI), .contactorClosing(closing),
      .currentCommand(currentCommand), .voltageCommand(voltageCommand),
      .powerCap(powerCap), .overshootCeiling(overshootCeiling),
      .zeroCurrentMode(zeroCurrentMode), .errorStop(errorStop),
      .advertisedMaxCurrent(advertisedMaxCurrent), .reportPending(reportPending));

   vehicle_model i_veh (.sys_clk(sys_clk), .wbRsp(wbRsp), .wbReq(wbReq), .stopReq());

   ////////////////////////////////////////////////////////////////////////////////
   // Compare, verdict and hang guard
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      testsRun++;
      if (got !== exp)
      begin
         nErrors++;
         $display("BAD %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", testsRun, nErrors);
      if (nErrors == 0 && testsRun > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         nErrors++;
         summarize();
      end
   end

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      // tgtI tgtV reqP maxI maxV maxP | volt | expI expV expZ cap ovs
      rows[0] = {16'h0064, 16'h0FA0, 32'h05F5E100, 16'h07D0, 16'h1388, 32'h05F5E100,
         16'h0FA0, 16'h0064, 16'h0FA0, 1'h0, 32'h047868C0, 17'h0157C};
      rows[1] = {16'h0005, 16'h0FA0, 32'h05F5E100, 16'h07D0, 16'h1388, 32'h05F5E100,
         16'h2710, 16'h0000, 16'h0FA0, 1'h1, 32'h047868C0, 17'h0157C};
      rows[2] = {16'h0BB8, 16'h0FA0, 32'h05F5E100, 16'h07D0, 16'h1388, 32'h05F5E100,
         16'h0FA0, 16'h07D0, 16'h0FA0, 1'h0, 32'h047868C0, 17'h0157C};
      rows[3] = {16'h0064, 16'h3E80, 32'h05F5E100, 16'h07D0, 16'h1388, 32'h05F5E100,
         16'h0FA0, 16'h0064, 16'h3A98, 1'h0, 32'h047868C0, 17'h0157C};
      rows[4] = {16'h0064, 16'h0FA0, 32'h00009C40, 16'h07D0, 16'h07D0, 32'h05F5E100,
         16'h0FA0, 16'h0000, 16'h0FA0, 1'h1, 32'h047868C0, 17'h009C4};
      rows[5] = {16'h0BB8, 16'h0FA0, 32'h05F5E100, 16'h1388, 16'h1F40, 32'h003D0900,
         16'h0FA0, 16'h03E8, 16'h0FA0, 1'h0, 32'h003D0900, 17'h02260};
      settle(5);
      check("zcmInReset", 32'h1, 32'(zeroCurrentMode));
      check("stopInReset", 32'h0, 32'(errorStop));
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'h0;
      // Load a sane demand before enabling, so no guard starts from reset values
      i_veh.send(rows[0].m);
      i_veh.xfer(1'h1, REG_CTRL, 32'h00000001, rd);
      foreach (rows[k])
      begin
         @(posedge sys_clk);
         measV <= rows[k].volt;
         i_veh.send(rows[k].m);
         settle(3);
         check("cmdI", 32'(rows[k].expI), 32'(currentCommand));
         check("zcm", 32'(rows[k].expZ), 32'(zeroCurrentMode));
         check("cap", rows[k].expCap, powerCap);
         check("ovs", 32'(rows[k].expOvs), 32'(overshootCeiling));
         if (rows[k].expZ === 1'h0)
            check("cmdV", 32'(rows[k].expV), 32'(voltageCommand));
      end
      // Inrush limit while contactors close
      i_veh.send(rows[0].m);
      closing <= 1'h1;
      settle(3);
      check("inrush", 32'(INRUSH_I), 32'(currentCommand));
      @(posedge sys_clk);
      closing <= 1'h0;
      // Flag is left pending from reset: clear it first so the limit change must set it
      i_veh.xfer(1'h1, REG_CTRL, 32'h00000005, rd);
      settle(3);
      check("pendingClr", 32'h0, 32'(reportPending));
      i_veh.xfer(1'h1, REG_SMAX_P, 32'h02000000, rd);
      settle(3);
      check("pending", 32'h1, 32'(reportPending));
      i_veh.xfer(1'h1, REG_CTRL, 32'h00000005, rd);
      settle(3);
      check("pendingClr", 32'h0, 32'(reportPending));
      i_veh.xfer(1'h0, REG_SMAX_P, 32'h0, rd);
      check("smaxRead", 32'h02000000, rd);
      i_veh.xfer(1'h0, 8'h3C, 32'h0, rd);
      check("unmapped", 32'h0, rd);
      i_veh.xfer(1'h1, REG_CMD_I, 32'h0000ABCD, rd);
      i_veh.xfer(1'h0, REG_CMD_I, 32'h0, rd);
      check("roCmdI", 32'h00000064, rd);
      // Measured power above the lowered station limit trims current below target
      m = rows[0].m;
      m.tgtI = 16'h0FA0;
      m.maxI = 16'h1388;
      m.reqP = 32'h01000000;
      measV <= 16'h2710;
      measI <= 16'h0FA0;
      i_veh.send(m);
      settle(3);
      check("pwrShort", 32'h00000D1B, 32'(currentCommand));
      @(posedge sys_clk);
      measV <= 16'h0FA0;
      measI <= 16'h0000;
      i_veh.send(rows[0].m);
      // Over-voltage: a lapse restarts the guard, a long hold stops
      measV <= STN_MAX_V;
      repeat (16) @(posedge sys_clk);
      measV <= 16'h0FA0;
      repeat (3) @(posedge sys_clk);
      measV <= STN_MAX_V;
      settle(15);
      check("ovRestart", 32'h0, 32'(errorStop));
      settle(15);
      check("ovStop", 32'h1, 32'(errorStop));
      check("advZero", 32'h0, 32'(advertisedMaxCurrent));
      check("stopZcm", 32'h1, 32'(zeroCurrentMode));
      @(posedge sys_clk);
      measV <= 16'h0FA0;
      i_veh.xfer(1'h1, REG_CTRL, 32'h00000003, rd);
      settle(3);
      check("errClr", 32'h0, 32'(errorStop));
      check("advBack", 32'(STN_MAX_I), 32'(advertisedMaxCurrent));
      // Low requested voltage
      m = rows[0].m;
      m.tgtV = 16'h03E8;
      i_veh.send(m);
      settle(30);
      check("uvStop", 32'h1, 32'(errorStop));
      i_veh.send(rows[0].m);
      i_veh.xfer(1'h1, REG_CTRL, 32'h00000003, rd);
      // Low target power (measured voltage times target current) held too long
      m.tgtV = 16'h0FA0;
      m.tgtI = 16'h000A;
      i_veh.send(m);
      #1;
      check("lowPwrEarly", 32'h0, 32'(zeroCurrentMode));
      settle(20);
      check("lowPwrZcm", 32'h1, 32'(zeroCurrentMode));
      summarize();
   end
endmodule
